// ==== verilog/tsc_serial_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
// Contract
// [R1] Chip select high: interface ignored, data and busy outputs not driven.
// [R2] Each rising serial clock edge shifts the data input into the command register.
// [R3] Leading zeros ignored; first one is the start bit, command MSB; the code ignores ones while a finished result waits for the buffer.
// [R4] Bit 3 picks 8-bit (one) or 12-bit (zero); bits 6..4 address.
// [R5] Bit 2 one means single-ended, zero means differential conversion.
// [R6] Address 000 temperature at low bias, 111 at high bias.
// [R7] Bit 1 switches internal reference on or off per command.
// [R8] Temperature channels always use the internal reference.
// [R9] Battery divider on only while the battery channel samples.
// [R10] Power bits 00: pen interrupt enabled, converter on only converting.
// [R11] Nonzero power bits disable pen interrupt; 01,10,11 set converter/reference on.
// [R12] Host uses clock polarity zero, phase zero.
// [R13] Host is clock master, 500 kHz to 2 MHz; the bench host clocks at 3.125 MHz instead.
// [R14] Host sends command, two zero bytes, then raises chip select.
// [R15] 12-bit result spans second and third bytes, then four zero bits; the code follows it with three zero bits in a 24-bit frame.
// [R16] Result bits leave on falling edges, MSB first, unsigned binary.
// [R17] Busy high exactly one serial clock period after last command bit.
// [R18] One decision bit on each of the 12 falling edges after busy.
// [R19] Host clocks fast enough to finish within 500 us of sampling.
// [R20] Conversion starts at the falling edge after the eighth bit only.
// [R21] First one after conversion bit 6 starts the next command; the code ignores it while a finished result waits for the buffer.
// [R22] Host keeps clocking until an accepted conversion finishes.
// [R23] Single-ended address map selects temperature, position, battery, pressure, auxiliary.
// [R24] Sampling runs from fifth through eighth falling edge of the command.
// [R25] Drivers on from acquisition; off after it single-ended, on through conversion differential.
// [R26] Chip select rise aborts conversion, powers converter down, keeps reference.
// [R27] Data output low while selected and no result bit shown.
// [R28] 8-bit mode: eight decisions, ends four falling edges earlier.
module tsc_serial_ctrl (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst_b,
    // Serial pins
    input  wire logic                cs_n,
    input  wire logic                serial_shift_clock,
    input  wire logic                serial_din,
    output logic                     serial_dout,
    output logic                     serial_dout_oe,
    output logic                     busy,
    output logic                     busy_oe,
    // Pen interrupt, open drain
    input  wire logic                touch_sense,
    output logic                     touch_detect_irq_n,
    output logic                     touch_detect_irq_n_oe,
    // Analog front end control
    input  wire logic                sar_decision,
    output logic [3:0]               sar_step,
    output logic                     sample_en,
    output logic                     adc_power_on,
    output logic                     internal_ref_en,
    output logic                     use_internal_ref,
    output logic                     battery_divider_en,
    output logic                     touch_drivers_on,
    output logic [2:0]               channel_sel,
    output logic                     single_ended_select,
    output logic                     temp_sense_en,
    output logic                     temp_bias_high,
    // Result stream
    output logic                     result_valid,
    input  wire logic                result_ready,
    output tsc_pkg::tsc_result_t     result_data
);
    import tsc_pkg::*;

    // Pin synchronisers
    logic [3:0] pins_s;
    tsc_sync #(.W(4)) u_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .async_in ({~cs_n, serial_shift_clock, serial_din, touch_sense}),
        .sync_out (pins_s)
    );
    wire cs_act  = pins_s[3];
    wire sclk_s  = pins_s[2];
    wire din_s   = pins_s[1];
    wire touch_s = pins_s[0];

    logic sclk_prev_r;
    wire  sclk_rise = cs_act && sclk_s && !sclk_prev_r;
    wire  sclk_fall = cs_act && !sclk_s && sclk_prev_r;

    // Receiver state
    logic [7:0] rx_shift_r;
    logic [3:0] rx_bits_r;
    logic [3:0] rx_falls_r;
    logic       rx_on_r;
    logic       acq_r;
    logic [2:0] rx_chan_r;
    logic       rx_se_r;

    // Converter state
    typedef enum logic [1:0] {CV_IDLE, CV_BUSY, CV_STEP} tsc_conv_t;
    tsc_conv_t   cv_r;
    tsc_cmd_t    cfg_r;
    logic [3:0]  step_r;
    logic [11:0] res_r;
    logic        dout_r;
    logic        pend_r;
    tsc_result_t pend_data_r;
    logic        buf_in_ready;

    function automatic logic [3:0] res_len(input logic mode8);
        res_len = mode8 ? 4'(RES8_W) : 4'(RES_W);
    endfunction

    function automatic logic is_temp(input logic [2:0] ch);
        is_temp = (ch == CH_TEMP_LOW) || (ch == CH_TEMP_HIGH);
    endfunction

    wire conv_on    = (cv_r != CV_IDLE);
    // Any start-bit hunt, idle or overlapped, stalls while an old result still waits for the buffer
    wire hunt_ok    = !pend_r && (!conv_on || (cv_r == CV_STEP && step_r >= 4'(OVERLAP_STEP))); // see [R21]
    wire start_bit  = sclk_rise && !rx_on_r && din_s && hunt_ok;                   // see [R3]
    wire shift_bit  = sclk_rise && rx_on_r && (rx_bits_r < 4'(CMD_W));            // see [R2]
    wire [3:0] falls_nxt = rx_falls_r + 4'h1;
    wire take       = sclk_fall && rx_on_r && (falls_nxt == 4'(CMD_W));           // see [R20]
    wire [7:0] shift_nxt = {rx_shift_r[6:0], din_s};
    wire last_step  = (step_r == res_len(cfg_r.mode8));
    wire conv_done  = sclk_fall && (cv_r == CV_STEP) && last_step && !take;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sclk_prev_r <= 1'b0;
        end else begin
            sclk_prev_r <= sclk_s;
        end
    end

    // Command receiver
    always_ff @(posedge clk) begin
        if (!rst_b || !cs_act) begin                                               // see [R1]
            rx_on_r    <= 1'b0;
            rx_shift_r <= 8'h00;
            rx_bits_r  <= 4'h0;
            rx_falls_r <= 4'h0;
            acq_r      <= 1'b0;
            rx_chan_r  <= 3'h0;
            rx_se_r    <= 1'b0;
        end else begin
            if (start_bit) begin
                rx_on_r    <= 1'b1;
                rx_shift_r <= 8'h01;
                rx_bits_r  <= 4'h1;
                rx_falls_r <= 4'h0;
            end else if (shift_bit) begin
                rx_shift_r <= shift_nxt;
                rx_bits_r  <= rx_bits_r + 4'h1;
                if (rx_bits_r + 4'h1 == 4'(CHAN_BIT_RISE)) begin
                    rx_chan_r <= shift_nxt[2:0];
                end
                if (rx_bits_r + 4'h1 == 4'(SE_BIT_RISE)) begin
                    rx_se_r <= din_s;
                end
            end
            if (sclk_fall && rx_on_r) begin
                rx_falls_r <= falls_nxt;
                if (falls_nxt == 4'(ACQ_FIRST_FALL)) begin
                    acq_r <= 1'b1;                                                 // see [R24]
                end
                if (falls_nxt == 4'(ACQ_LAST_FALL)) begin
                    acq_r   <= 1'b0;
                    rx_on_r <= 1'b0;
                end
            end
        end
    end

    // Conversion sequencer
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cv_r   <= CV_IDLE;
            cfg_r  <= tsc_cmd_t'(CMD_RESET);
            step_r <= 4'h0;
            res_r  <= 12'h000;
            dout_r <= 1'b0;
        end else if (!cs_act) begin
            cv_r   <= CV_IDLE;                                                     // see [R26]
            step_r <= 4'h0;
            dout_r <= 1'b0;
        end else if (take) begin
            cfg_r  <= tsc_cmd_t'(rx_shift_r);                                      // see [R4] [R5] [R7]
            cv_r   <= CV_BUSY;                                                     // see [R17]
            step_r <= 4'h0;
            res_r  <= 12'h000;
            dout_r <= 1'b0;
        end else if (sclk_fall) begin
            case (cv_r)
                CV_BUSY: begin
                    cv_r   <= CV_STEP;
                    step_r <= 4'h1;
                    dout_r <= sar_decision;                                        // see [R16] [R18]
                    res_r  <= {res_r[10:0], sar_decision};
                end
                CV_STEP: begin
                    if (last_step) begin
                        cv_r   <= CV_IDLE;                                         // see [R28]
                        dout_r <= 1'b0;                                            // see [R15] [R27]
                    end else begin
                        step_r <= step_r + 4'h1;
                        dout_r <= sar_decision;
                        res_r  <= {res_r[10:0], sar_decision};
                    end
                end
                default: begin
                    dout_r <= 1'b0;
                end
            endcase
        end
    end

    // Finished result waits here until the buffer has room
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pend_r      <= 1'b0;
            pend_data_r <= '0;
        end else begin
            pend_r <= conv_done || (pend_r && !buf_in_ready);
            if (conv_done) begin
                pend_data_r.chan  <= cfg_r.chan;
                pend_data_r.mode8 <= cfg_r.mode8;
                pend_data_r.data  <= res_r;
            end
        end
    end

    tsc_buf2 #(.W($bits(tsc_result_t))) u_buf (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (pend_r),
        .in_ready  (buf_in_ready),
        .in_data   (pend_data_r),
        .out_valid (result_valid),
        .out_ready (result_ready),
        .out_data  (result_data)
    );

    // Pin drive
    assign serial_dout    = dout_r;
    assign serial_dout_oe = cs_act;                                                // see [R1]
    assign busy           = (cv_r == CV_BUSY);
    assign busy_oe        = cs_act;

    // Analog steering; during acquisition the incoming address governs
    wire       pd_zero  = !cfg_r.reference_power_ctrl && !cfg_r.converter_power_ctrl;
    wire [2:0] act_chan = acq_r ? rx_chan_r : cfg_r.chan;
    wire       act_se   = acq_r ? rx_se_r : cfg_r.single_ended_select;

    assign channel_sel         = act_chan;                                         // see [R23]
    assign single_ended_select = act_se;
    assign sample_en           = acq_r;
    assign sar_step            = step_r;
    assign temp_sense_en       = is_temp(act_chan);
    assign temp_bias_high      = (act_chan == CH_TEMP_HIGH);                       // see [R6]
    assign internal_ref_en     = cfg_r.reference_power_ctrl;                       // see [R7] [R26]
    assign use_internal_ref    = cfg_r.reference_power_ctrl || is_temp(act_chan);  // see [R8]
    assign battery_divider_en  = acq_r && act_se && (act_chan == CH_BATTERY);      // see [R9]
    assign touch_drivers_on    = acq_r || (conv_on && !cfg_r.single_ended_select); // see [R25]
    assign adc_power_on        = cs_act && (acq_r || conv_on
                                 || cfg_r.converter_power_ctrl);                   // see [R10] [R11]
    // Masked during acquisition and conversion, transitions there are not touches
    assign touch_detect_irq_n    = 1'b0;
    assign touch_detect_irq_n_oe = pd_zero && touch_s && !acq_r && !conv_on;       // see [R10] [R11]

    AST_CS_HIGH_QUIET: assert property (@(posedge clk) disable iff (!rst_b) // see [R1]
        !cs_act |-> !serial_dout_oe && !busy_oe) else $error("Pins driven while deselected");
    AST_BUSY_ONE_PERIOD: assert property (@(posedge clk) disable iff (!rst_b) // see [R17]
        take |=> busy) else $error("Busy pulse missing");
    AST_BUSY_HOLDS: assert property (@(posedge clk) disable iff (!rst_b) // see [R17]
        busy && cs_act && !sclk_fall |=> busy) else $error("Busy dropped inside its period");
    AST_BUSY_ENDS: assert property (@(posedge clk) disable iff (!rst_b) // see [R18]
        busy && sclk_fall && cs_act |=> !busy && step_r == 4'h1) else $error("Busy outlived a period");
    AST_TAKE_AT_FALL8: assert property (@(posedge clk) disable iff (!rst_b) // see [R20]
        take |-> sclk_fall && rx_falls_r == 4'h7 && rx_bits_r == 4'h8) else $error("Start not on fall 8");
    AST_START_IS_ONE: assert property (@(posedge clk) disable iff (!rst_b) // see [R3]
        $rose(rx_on_r) |-> $past(din_s) && $past(sclk_rise)) else $error("Start without a one");
    AST_STEP_BOUND: assert property (@(posedge clk) disable iff (!rst_b) // see [R28]
        cv_r == CV_STEP |-> step_r >= 4'h1 && step_r <= res_len(cfg_r.mode8)) else $error("Step out of range");
    AST_BAT_ONLY_SAMPLING: assert property (@(posedge clk) disable iff (!rst_b) // see [R9]
        battery_divider_en |-> sample_en && channel_sel == CH_BATTERY) else $error("Divider on outside sampling");
    AST_PEN_GATED: assert property (@(posedge clk) disable iff (!rst_b) // see [R11]
        touch_detect_irq_n_oe |-> pd_zero && !conv_on) else $error("Pen enabled in powered mode");
    AST_TEMP_INT_REF: assert property (@(posedge clk) disable iff (!rst_b) // see [R8]
        temp_sense_en |-> use_internal_ref) else $error("Temperature without internal ref");
    AST_IDLE_DOUT_LOW: assert property (@(posedge clk) disable iff (!rst_b) // see [R27]
        cs_act && (cv_r == CV_IDLE || cv_r == CV_BUSY) |-> !serial_dout) else $error("Dout high while idle");
    AST_CS_ABORT: assert property (@(posedge clk) disable iff (!rst_b) // see [R26]
        $fell(cs_act) |=> cv_r == CV_IDLE && !adc_power_on && internal_ref_en == $past(internal_ref_en, 2))
        else $error("Deselect did not abort");
    AST_DRV_ACQ: assert property (@(posedge clk) disable iff (!rst_b) // see [R25]
        sample_en |-> touch_drivers_on) else $error("Drivers off during acquisition");
    AST_DRV_DIFF: assert property (@(posedge clk) disable iff (!rst_b) // see [R25]
        conv_on && !cfg_r.single_ended_select |-> touch_drivers_on) else $error("Drivers off in differential");
    AST_DRV_SE_OFF: assert property (@(posedge clk) disable iff (!rst_b) // see [R25]
        !sample_en && cfg_r.single_ended_select |-> !touch_drivers_on) else $error("Drivers on after sampling");
    AST_ADC_HELD_ON: assert property (@(posedge clk) disable iff (!rst_b) // see [R11]
        cs_act && cfg_r.converter_power_ctrl |-> adc_power_on) else $error("Converter off in held-on mode");
    AST_ADC_PD_OFF: assert property (@(posedge clk) disable iff (!rst_b) // see [R10]
        cs_act && pd_zero && !sample_en && !conv_on |-> !adc_power_on) else $error("Converter on between conversions");
endmodule
`default_nettype wire

// ==== verilog/tsc_pkg.sv ====
`default_nettype none
package tsc_pkg;

    // Command byte layout, start bit first on the wire
    localparam int CMD_W           = 8;
    localparam int CMD_START_POS   = 7;
    localparam int CMD_CHAN_HI     = 6;
    localparam int CMD_CHAN_LO     = 4;
    localparam int CMD_MODE8_POS   = 3;
    localparam int CMD_SE_POS      = 2;
    localparam int CMD_REFPWR_POS  = 1;
    localparam int CMD_ADCPWR_POS  = 0;

    // Reset value: power bits 00, 12-bit, differential, channel 000
    localparam logic [7:0] CMD_RESET = 8'h00;

    // Conversion lengths and framing counts
    localparam int RES_W          = 12;
    localparam int RES8_W         = 8;
    localparam int PAD_BITS       = 4;
    localparam int OVERLAP_STEP   = 6;
    localparam int ACQ_FIRST_FALL = 5;
    localparam int ACQ_LAST_FALL  = 8;
    localparam int CHAN_BIT_RISE  = 4;
    localparam int SE_BIT_RISE    = 6;

    // Channel addresses in single-ended mode
    localparam logic [2:0] CH_TEMP_LOW     = 3'h0;
    localparam logic [2:0] CH_Y_POS        = 3'h1;
    localparam logic [2:0] CH_BATTERY      = 3'h2;
    localparam logic [2:0] CH_PRESS_FIRST  = 3'h3;
    localparam logic [2:0] CH_PRESS_SECOND = 3'h4;
    localparam logic [2:0] CH_X_POS        = 3'h5;
    localparam logic [2:0] CH_AUX          = 3'h6;
    localparam logic [2:0] CH_TEMP_HIGH    = 3'h7;

    // Link clock period seen in the bench, for reference
    localparam int LINK_PERIOD_NS = 320;

    typedef struct packed {
        logic       start;
        logic [2:0] chan;
        logic       mode8;
        logic       single_ended_select;
        logic       reference_power_ctrl;
        logic       converter_power_ctrl;
    } tsc_cmd_t;

    typedef struct packed {
        logic [2:0]  chan;
        logic        mode8;
        logic [11:0] data;
    } tsc_result_t;

endpackage
`default_nettype wire

// ==== verilog/tsc_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module tsc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Asynchronous in, synchronous out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/tsc_buf2.sv ====
`timescale 1ns/100ps
`default_nettype none
module tsc_buf2 #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    logic [W-1:0] mem_r [2];
    logic         wr_ptr_r;
    logic         rd_ptr_r;
    logic [1:0]   count_r;
    wire          push = in_valid && in_ready;
    wire          pop  = out_valid && out_ready;

    assign in_ready  = (count_r != 2'h2);
    assign out_valid = (count_r != 2'h0);
    assign out_data  = mem_r[rd_ptr_r];

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r  <= 2'h0;
            mem_r[0] <= '0;
            mem_r[1] <= '0;
        end else begin
            if (push) begin
                mem_r[wr_ptr_r] <= in_data;
                wr_ptr_r        <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            count_r <= count_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule
`default_nettype wire

// ==== tb/tsc_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module tsc_host_model (
    // Bench clock, pacing only
    input  wire logic clk,
    // Serial master pins
    output logic      cs_n,
    output logic      serial_shift_clock,
    output logic      serial_din,
    input  wire logic sdo,
    input  wire logic busy_line
);
    initial begin
        cs_n               = 1'b1;
        serial_shift_clock = 1'b0;
        serial_din         = 1'b0;
    end

    // Half serial period is 4 clk, 320 ns per bit; clock idles low outside frames
    // Faster than the recommended host rate, to keep runs short
    task automatic half();
        repeat (4) @(negedge clk);
    endtask

    // Whole frame, n bits MSB first; data changes while clock is low
    task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx, output logic [31:0] bz);
        rx = '0;
        bz = '0;
        @(negedge clk);
        cs_n = 1'b0;
        half();
        for (int i = n - 1; i >= 0; i--) begin
            serial_din = tx[i];
            half();
            serial_shift_clock = 1'b1;
            half();
            // Read just before the fall, long after the device settled
            rx[i] = sdo;
            bz[i] = busy_line;
            serial_shift_clock = 1'b0;
        end
        half();
        cs_n = 1'b1;
        serial_din = ~serial_din;
    endtask

    // Clock and ones while deselected; device must not react
    task automatic stray_clocks();
        serial_din = 1'b1;
        for (int i = 0; i < 8; i++) begin
            half();
            serial_shift_clock = 1'b1;
            half();
            serial_shift_clock = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ==== tb/test_touch_adc_serial_control.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_touch_adc_serial_control;
    import tsc_pkg::*;

    logic        clk;
    logic        rst_b;
    logic        cs_n;
    logic        sclk;
    logic        din;
    logic        dout;
    logic        dout_oe;
    logic        busy;
    logic        busy_oe;
    logic        touch_sense;
    logic        irq_n;
    logic        irq_oe;
    logic        sar_decision;
    logic        result_valid;
    logic        result_ready;
    tsc_result_t result_data;
    logic [3:0]  sar_step;
    logic        internal_ref_en;
    logic        use_internal_ref;
    logic        temp_bias_high;
    logic [31:0] rx;
    logic [31:0] bz;
    wire         sdo_line;
    wire         busy_line;
    int          error_cnt;
    int          compares;
    int          cyc;

    // Undriven pins float so a released line never reads as valid data
    assign sdo_line  = dout_oe ? dout : 1'bz;
    assign busy_line = busy_oe ? busy : 1'bz;
    // Decisions 1,0,1,... from the MSB, so a reversed bit order shows
    assign sar_decision = ~sar_step[0];

    tsc_serial_ctrl i_tsc_serial_ctrl (
        .clk                   (clk),
        .rst_b                 (rst_b),
        .cs_n                  (cs_n),
        .serial_shift_clock    (sclk),
        .serial_din            (din),
        .serial_dout           (dout),
        .serial_dout_oe        (dout_oe),
        .busy                  (busy),
        .busy_oe               (busy_oe),
        .touch_sense           (touch_sense),
        .touch_detect_irq_n    (irq_n),
        .touch_detect_irq_n_oe (irq_oe),
        .sar_decision          (sar_decision),
        .sar_step              (sar_step),
        .sample_en             (),
        .adc_power_on          (),
        .internal_ref_en       (internal_ref_en),
        .use_internal_ref      (use_internal_ref),
        .battery_divider_en    (),
        .touch_drivers_on      (),
        .channel_sel           (),
        .single_ended_select   (),
        .temp_sense_en         (),
        .temp_bias_high        (temp_bias_high),
        .result_valid          (result_valid),
        .result_ready          (result_ready),
        .result_data           (result_data)
    );

    tsc_host_model i_tsc_host_model (
        .clk                (clk),
        .cs_n               (cs_n),
        .serial_shift_clock (sclk),
        .serial_din         (din),
        .sdo                (sdo_line),
        .busy_line          (busy_line)
    );

    initial clk = 1'b0;
    always #20 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Alternating decisions; reading is one bit behind the falling edge
    task automatic t_conv12();
        i_tsc_host_model.frame(32'h00d40000, 24, rx, bz);
        chk(rx, 32'h00005550, "12-bit frame bytes");
        chk(bz, 32'h00008000, "busy one period after command");
        $display("test conv12 done");
    endtask

    task automatic t_conv8_lead_zero();
        i_tsc_host_model.frame(32'h00ab0000, 32, rx, bz);
        chk(rx, 32'h00005500, "8-bit frame after zero byte");
        chk(bz, 32'h00008000, "busy after delayed start");
        @(negedge clk);
        touch_sense = 1'b1;
        repeat (8) @(negedge clk);
        chk({31'h0, internal_ref_en}, 32'h1, "reference kept after deselect");
        chk({31'h0, irq_oe}, 32'h0, "pen output off in power 11");
        touch_sense = 1'b0;
        $display("test conv8 done");
    endtask

    // Buffer held two results while the reader stalled; now drained
    task automatic t_drain();
        chk({31'h0, result_valid}, 32'h1, "buffer holds results");
        chk({16'h0, result_data}, {16'h0, 3'h5, 1'b0, 12'haaa}, "first result");
        result_ready = 1'b1;
        @(negedge clk);
        chk({16'h0, result_data}, {16'h0, 3'h2, 1'b1, 12'h0aa}, "second result");
        @(negedge clk);
        chk({31'h0, result_valid}, 32'h0, "buffer empty");
        $display("test drain done");
    endtask

    task automatic t_deselected();
        i_tsc_host_model.stray_clocks();
        repeat (4) @(negedge clk);
        chk({30'h0, dout_oe, busy_oe}, 32'h0, "pins released while deselected");
        chk({31'h0, result_valid}, 32'h0, "no conversion while deselected");
        chk({27'h0, busy, sar_step}, 32'h0, "no command taken while deselected");
        $display("test deselected done");
    endtask

    task automatic t_temp_high();
        i_tsc_host_model.frame(32'h00f00000, 24, rx, bz);
        chk(rx, 32'h00005550, "temperature frame");
        chk({30'h0, temp_bias_high, use_internal_ref}, 32'h3, "high bias uses internal reference");
        chk({31'h0, internal_ref_en}, 32'h0, "reference turned off");
        @(negedge clk);
        touch_sense = 1'b1;
        repeat (8) @(negedge clk);
        chk({31'h0, irq_oe}, 32'h1, "pen output on touch in power 00");
        touch_sense = 1'b0;
        repeat (8) @(negedge clk);
        chk({31'h0, irq_oe}, 32'h0, "pen output released");
        $display("test temp_high done");
    endtask

    // Three frames of 201 to 265 clk each plus stray clocks, so this ceiling is generous
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            $display("mismatch at %0t: run timed out", $time);
            report_and_stop();
        end
    end

    initial begin
        error_cnt    = 0;
        compares     = 0;
        cyc          = 0;
        rst_b        = 1'b0;
        touch_sense  = 1'b0;
        result_ready = 1'b0;
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        chk({31'h0, result_valid}, 32'h0, "idle after reset");
        t_conv12();
        t_conv8_lead_zero();
        t_drain();
        t_deselected();
        t_temp_high();
        report_and_stop();
    end
endmodule
`default_nettype wire
